// file: shared/qrw_pkg.sv
// Constants and types shared by the quad read / wrap / four-wire flash sequencer
package qrw_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_WORD_READ = 8'hE7;
  localparam logic [7:0] OP_OCTAL_READ = 8'hE3;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_WRAP_SETUP = 8'h77;
  localparam logic [7:0] OP_READ_PARAM = 8'hC0;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_ENTER_FW = 8'h38;
  localparam logic [7:0] OP_EXIT_FW = 8'hFF;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;

  // ****************************************
  // Phase lengths in bits, lane widths
  // ****************************************
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] WRAP_ARG_BITS = 6'h20;
  localparam logic [5:0] PARAM_ARG_BITS = 6'h08;
  localparam logic [5:0] LANE_ONE = 6'h01;
  localparam logic [5:0] LANE_FOUR = 6'h04;

  // ****************************************
  // Dummy clock counts
  // ****************************************
  localparam logic [3:0] DMY_STD_QUAD = 4'h4;
  localparam logic [3:0] DMY_WORD = 4'h2;
  localparam logic [3:0] DMY_OCTAL = 4'h0;
  localparam logic [3:0] DMY_P_LOW = 4'h4;
  localparam logic [3:0] DMY_P_MID = 4'h6;
  localparam logic [3:0] DMY_P_HIGH = 4'h8;
  localparam logic [3:0] DMY_MODE_CLKS = 4'h2;
  localparam logic [1:0] DSEL_MID = 2'h2;
  localparam logic [1:0] DSEL_HIGH = 2'h3;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CONT_POS = 4;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_POS = 5;
  localparam int PARAM_DMY_POS = 4;
  localparam int PARAM_LEN_POS = 0;
  localparam int PAGE_POS = 8;
  localparam logic [1:0] CONT_MATCH = 2'h2;
  localparam logic [7:0] WRAP_BASE_MASK = 8'h07;
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  localparam logic [1:0] DMY_SEL_RST = 2'h0;

  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_ARG, ST_IGNORE} qrw_state_t;

endpackage

// file: rtl/qrw_flash_ctrl.sv
// Quad read, wrap, four-wire command mode and page erase sequencer of a serial NOR flash
`timescale 1ns/1ps
module qrw_flash_ctrl
  import qrw_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int PAGE_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic quad_enable_bit,
  input wire logic erase_done,
  output logic erase_req,
  output logic [PAGE_W-1:0] erase_page,
  output logic four_wire_command_mode,
  output logic cont_read_active,
  output logic write_enable_latch,
  output logic wrap_disable_bit,
  output logic [1:0] wrap_length_select,
  output logic [1:0] dummy_count_select,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_data
);

  // ****************************************
  // Link domain: frame state, cleared by chip select
  // ****************************************
  qrw_state_t st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic nib_lo_r, nib_lo_nxt;
  logic wrap_on_r, wrap_on_nxt;
  logic [3:0] dmy_tgt_r, dmy_tgt_nxt;
  logic [3:0] io_out_r;
  logic [3:0] io_oe_r;

  // Link domain: state kept across frames
  logic fw_mode_r;
  logic cont_r;
  logic [7:0] cont_cmd_r;
  logic wen_latch_r;
  logic wrap_dis_r;
  logic [1:0] wrap_len_r;
  logic [1:0] dmy_sel_r;
  logic erase_tgl_r;
  logic [PAGE_W-1:0] erase_page_r;
  logic lrst_s1_r, lrst_s2_r;
  logic qe_s1_r, qe_s2_r;
  logic done_s1_r, done_s2_r, done_s3_r;

  // Events from the frame decoder to the kept state
  logic ev_write_enable_cmd, ev_fw_on, ev_fw_off, ev_cont_clr;
  logic ev_erase, ev_mode, ev_wrap_set, ev_param_set;

  // ****************************************
  // Decode wires
  // ****************************************
  wire cont_start = (st_r == ST_CMD) && (cnt_r == 6'h00) && cont_r;
  wire quad_cmd = (cmd_r == OP_QUAD_IO_READ) || (cmd_r == OP_WORD_READ) || (cmd_r == OP_OCTAL_READ);
  wire wide = fw_mode_r || quad_cmd || cont_start;
  wire [5:0] lane_w = wide ? LANE_FOUR : LANE_ONE;
  wire [5:0] cnt_sum = cnt_r + lane_w;
  wire [31:0] sh_in = wide ? {sh_r[27:0], io_in} : {sh_r[30:0], io_in[0]};
  wire [7:0] opc = sh_in[7:0];
  wire quad_ok = fw_mode_r || qe_s2_r;
  wire opc_quad = (opc == OP_QUAD_IO_READ) || (opc == OP_WORD_READ) || (opc == OP_OCTAL_READ);
  wire opc_fw_read = fw_mode_r && ((opc == OP_FAST_READ) || (opc == OP_WRAP_READ));
  wire opc_to_addr = (opc_quad && quad_ok) || opc_fw_read || (opc == OP_PAGE_ERASE);
  wire opc_to_arg = (!fw_mode_r && (opc == OP_WRAP_SETUP)) || (fw_mode_r && (opc == OP_READ_PARAM));
  wire is_erase = (cmd_r == OP_PAGE_ERASE);

  // Dummy totals from the read parameters
  wire [3:0] dmy_param = (dmy_sel_r == DSEL_HIGH) ? DMY_P_HIGH :
                         (dmy_sel_r == DSEL_MID) ? DMY_P_MID : DMY_P_LOW;
  wire [3:0] dmy_quad = fw_mode_r ? (dmy_param - DMY_MODE_CLKS) : DMY_STD_QUAD;
  wire [3:0] mode_dmy = (cmd_r == OP_WORD_READ) ? DMY_WORD :
                        (cmd_r == OP_OCTAL_READ) ? DMY_OCTAL : dmy_quad;

  // Wrap decisions
  wire wrap_std = !fw_mode_r && !wrap_dis_r &&
                  ((cmd_r == OP_QUAD_IO_READ) || (cmd_r == OP_WORD_READ));
  wire wrap_fw = fw_mode_r && (cmd_r == OP_WRAP_READ);
  wire [7:0] wrap_mask = 8'((WRAP_BASE_MASK << wrap_len_r) | WRAP_BASE_MASK);
  wire [ADDR_W-1:0] addr_inc = addr_r + ADDR_W'(1);
  wire [7:0] wrap_low = (addr_r[7:0] & ~wrap_mask) | (addr_inc[7:0] & wrap_mask);
  wire [ADDR_W-1:0] addr_step = wrap_on_r ? {addr_r[ADDR_W-1:8], wrap_low} : addr_inc;

  // Argument length of the configuration commands
  wire [5:0] arg_bits = (cmd_r == OP_WRAP_SETUP) ? WRAP_ARG_BITS : PARAM_ARG_BITS;
  wire [5:0] dmy_cnt_inc = cnt_r + 6'h01;

  // ****************************************
  // Frame next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_sum;
    sh_nxt = sh_in;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    nib_lo_nxt = nib_lo_r;
    wrap_on_nxt = wrap_on_r;
    dmy_tgt_nxt = dmy_tgt_r;
    ev_write_enable_cmd = 1'b0;
    ev_fw_on = 1'b0;
    ev_fw_off = 1'b0;
    ev_cont_clr = 1'b0;
    ev_erase = 1'b0;
    ev_mode = 1'b0;
    ev_wrap_set = 1'b0;
    ev_param_set = 1'b0;
    case (st_r)
      ST_CMD: begin
        if (cont_start) begin
          // Opcode skipped: this clock already carries address
          cmd_nxt = cont_cmd_r;
          st_nxt = ST_ADDR;
        end else if (cnt_sum == OPC_BITS) begin
          cmd_nxt = opc;
          cnt_nxt = 6'h00;
          ev_write_enable_cmd = (opc == OP_WRITE_ENABLE);
          ev_fw_on = !fw_mode_r && (opc == OP_ENTER_FW) && qe_s2_r;
          ev_fw_off = fw_mode_r && (opc == OP_EXIT_FW);
          ev_cont_clr = !fw_mode_r && (opc == OP_EXIT_FW);
          if (opc_to_addr) begin
            st_nxt = ST_ADDR;
          end else if (opc_to_arg) begin
            st_nxt = ST_ARG;
          end else begin
            st_nxt = ST_IGNORE;
          end
        end
      end
      ST_ADDR: begin
        if (cnt_sum == ADDR_BITS) begin
          addr_nxt = sh_in[ADDR_W-1:0];
          cnt_nxt = 6'h00;
          wrap_on_nxt = wrap_std || wrap_fw;
          if (is_erase) begin
            ev_erase = wen_latch_r;
            st_nxt = ST_IGNORE;
          end else if (quad_cmd) begin
            st_nxt = ST_MODE;
          end else begin
            dmy_tgt_nxt = dmy_param;
            st_nxt = ST_DUMMY;
          end
        end
      end
      ST_MODE: begin
        if (cnt_sum == MODE_BITS) begin
          ev_mode = 1'b1;
          cnt_nxt = 6'h00;
          dmy_tgt_nxt = mode_dmy;
          nib_lo_nxt = 1'b0;
          st_nxt = (mode_dmy == DMY_OCTAL) ? ST_DATA : ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        cnt_nxt = dmy_cnt_inc;
        if (dmy_cnt_inc == {2'h0, dmy_tgt_r}) begin
          cnt_nxt = 6'h00;
          nib_lo_nxt = 1'b0;
          st_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        cnt_nxt = cnt_r;
        nib_lo_nxt = !nib_lo_r;
        if (nib_lo_r) begin
          addr_nxt = addr_step;
        end
      end
      ST_ARG: begin
        if (cnt_sum == arg_bits) begin
          ev_wrap_set = (cmd_r == OP_WRAP_SETUP);
          ev_param_set = (cmd_r == OP_READ_PARAM);
          cnt_nxt = 6'h00;
          st_nxt = ST_IGNORE;
        end
      end
      default: begin
        cnt_nxt = cnt_r;
        st_nxt = ST_IGNORE;
      end
    endcase
  end

  // Chip select high ends every frame at once, whatever sclk does
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_r <= ST_CMD;
      cnt_r <= 6'h00;
      sh_r <= 32'h00000000;
      cmd_r <= 8'h00;
      addr_r <= '0;
      nib_lo_r <= 1'b0;
      wrap_on_r <= 1'b0;
      dmy_tgt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      nib_lo_r <= nib_lo_nxt;
      wrap_on_r <= wrap_on_nxt;
      dmy_tgt_r <= dmy_tgt_nxt;
    end
  end

  // ****************************************
  // Output lanes, launched on the falling edge
  // ****************************************
  wire data_phase = (st_r == ST_DATA);
  wire [3:0] nib_sel = nib_lo_r ? mem_data[3:0] : mem_data[7:4];

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else begin
      io_out_r <= data_phase ? nib_sel : 4'h0;
      io_oe_r <= {4{data_phase}};
    end
  end

  assign io_out = io_out_r;
  assign io_oe = io_oe_r;
  assign mem_addr = addr_r;

  // ****************************************
  // Link domain synchronisers
  // ****************************************
  logic qe_r;
  logic done_tgl_r;

  always_ff @(posedge sclk) begin
    lrst_s1_r <= sys_rst;
    lrst_s2_r <= lrst_s1_r;
    qe_s1_r <= qe_r;
    qe_s2_r <= qe_s1_r;
    done_s1_r <= done_tgl_r;
    done_s2_r <= done_s1_r;
    done_s3_r <= done_s2_r;
  end

  wire done_ev = done_s2_r ^ done_s3_r;

  // ****************************************
  // Link domain kept state
  // ****************************************
  // No mode switch touches latch, suspend or wrap length
  always_ff @(posedge sclk) begin
    if (lrst_s2_r) begin
      fw_mode_r <= 1'b0;
      cont_r <= 1'b0;
      cont_cmd_r <= 8'h00;
      wen_latch_r <= 1'b0;
      wrap_dis_r <= WRAP_DIS_RST;
      wrap_len_r <= WRAP_LEN_RST;
      dmy_sel_r <= DMY_SEL_RST;
      erase_tgl_r <= 1'b0;
      erase_page_r <= '0;
    end else begin
      if (ev_fw_on) begin
        fw_mode_r <= 1'b1;
      end else if (ev_fw_off) begin
        fw_mode_r <= 1'b0;
      end
      if (ev_mode) begin
        cont_r <= (sh_in[CONT_POS +: 2] == CONT_MATCH);
        cont_cmd_r <= cmd_r;
      end else if (ev_cont_clr) begin
        cont_r <= 1'b0;
      end
      // Set wins over a completion arriving in the same edge
      if (ev_write_enable_cmd) begin
        wen_latch_r <= 1'b1;
      end else if (done_ev) begin
        wen_latch_r <= 1'b0;
      end
      if (ev_wrap_set) begin
        wrap_dis_r <= sh_in[WRAP_DIS_POS];
        wrap_len_r <= sh_in[WRAP_LEN_POS +: 2];
      end else if (ev_param_set) begin
        dmy_sel_r <= sh_in[PARAM_DMY_POS +: 2];
        wrap_len_r <= sh_in[PARAM_LEN_POS +: 2];
      end
      if (ev_erase) begin
        erase_tgl_r <= !erase_tgl_r;
        erase_page_r <= addr_nxt[PAGE_POS +: PAGE_W];
      end
    end
  end

  // ****************************************
  // System domain: erase hand-off and status
  // ****************************************
  logic es1_r, es2_r, es3_r;
  logic erase_req_r;
  logic [PAGE_W-1:0] erase_page_out_r;
  logic [7:0] st_s1_r, st_s2_r;

  // Page word is stable long before its toggle arrives
  wire erase_ev = es2_r ^ es3_r;
  wire [7:0] link_status = {dmy_sel_r, wrap_len_r, wrap_dis_r, wen_latch_r, cont_r, fw_mode_r};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      qe_r <= 1'b0;
      done_tgl_r <= 1'b0;
      es1_r <= 1'b0;
      es2_r <= 1'b0;
      es3_r <= 1'b0;
      erase_req_r <= 1'b0;
      erase_page_out_r <= '0;
      st_s1_r <= 8'h00;
      st_s2_r <= 8'h00;
    end else begin
      qe_r <= quad_enable_bit;
      es1_r <= erase_tgl_r;
      es2_r <= es1_r;
      es3_r <= es2_r;
      erase_req_r <= erase_ev;
      if (erase_ev) begin
        erase_page_out_r <= erase_page_r;
      end
      if (erase_done) begin
        done_tgl_r <= !done_tgl_r;
      end
      st_s1_r <= link_status;
      st_s2_r <= st_s1_r;
    end
  end

  assign erase_req = erase_req_r;
  assign erase_page = erase_page_out_r;
  assign four_wire_command_mode = st_s2_r[0];
  assign cont_read_active = st_s2_r[1];
  assign write_enable_latch = st_s2_r[2];
  assign wrap_disable_bit = st_s2_r[3];
  assign wrap_length_select = st_s2_r[5:4];
  assign dummy_count_select = st_s2_r[7:6];

endmodule // qrw_flash_ctrl

// file: testbench/qrw_flash_ctrl_asserts.sv
// Concurrent checks on the ports of the flash sequencer
`timescale 1ns/1ps
module qrw_flash_ctrl_asserts #(
  parameter int PAGE_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic quad_enable_bit,
  input wire logic erase_req,
  input wire logic [PAGE_W-1:0] erase_page,
  input wire logic four_wire_command_mode,
  input wire logic cont_read_active,
  input wire logic write_enable_latch,
  input wire logic [1:0] wrap_length_select,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_oe
);
  // ****************
  // Link clocks per frame
  // ****************
  logic [5:0] rise_cnt_r;
  // Saturates so a long burst never folds back under the minimum
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_r <= 6'h00;
    end else if (rise_cnt_r != 6'h3F) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end
  // ****************
  // Properties
  // ****************
  erase_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) erase_req |=> !erase_req)
    else $error("erase request too long");
  page_hold_a: assert property (@(posedge clk) disable iff (sys_rst) !erase_req |-> $stable(erase_page))
    else $error("erase page moved");
  erase_wel_a: assert property (@(posedge clk) disable iff (sys_rst) erase_req |-> write_enable_latch)
    else $error("erase without latch");
  fw_qe_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(four_wire_command_mode) |-> quad_enable_bit)
    else $error("four-wire entry without quad enable");
  switch_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(four_wire_command_mode) |-> $stable(wrap_length_select) && $stable(write_enable_latch))
    else $error("mode switch lost state");
  oe_idle_a: assert property (@(posedge clk) disable iff (sys_rst) $past(cs_n) && cs_n |-> io_oe == 4'h0)
    else $error("lines driven while deselected");
  oe_stands_a: assert property (@(posedge sclk) disable iff (sys_rst || cs_n)
    io_oe == 4'hF |=> io_oe == 4'hF)
    else $error("data drive dropped in frame");
  data_late_a: assert property (@(posedge sclk) disable iff (sys_rst || cs_n)
    io_oe != 4'h0 |-> rise_cnt_r >= 6'h08)
    else $error("data before address and mode");
  erase_seen_c: cover property (@(posedge clk) erase_req);
  fw_entry_c: cover property (@(posedge clk) $rose(four_wire_command_mode));
  cont_arm_c: cover property (@(posedge clk) $rose(cont_read_active));
endmodule // qrw_flash_ctrl_asserts

bind qrw_flash_ctrl qrw_flash_ctrl_asserts #(.PAGE_W(PAGE_W)) u_qrw_flash_ctrl_asserts (
  .clk(clk), .sys_rst(sys_rst), .quad_enable_bit(quad_enable_bit), .erase_req(erase_req), .erase_page(erase_page),
  .four_wire_command_mode(four_wire_command_mode), .cont_read_active(cont_read_active),
  .write_enable_latch(write_enable_latch), .wrap_length_select(wrap_length_select), .sclk(sclk), .cs_n(cs_n),
  .io_oe(io_oe)
);

// file: testbench/qrw_host_model.sv
// Host controller model driving the link of the flash sequencer
`timescale 1ns/1ps
module qrw_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  // ****************
  // Wire and bit timing
  // ****************
  logic [3:0] drv_r = 4'h0;
  logic drv_en_r = 1'b1;
  // Released lanes show the inverse of the last value, never a stale copy
  assign io_in = (io_oe & io_out) | (~io_oe & (drv_en_r ? drv_r : ~drv_r));
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Clock pulses n times, chip select left as it stands, ending low
  task automatic idle(input int n);
    repeat (n) begin
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
  endtask
  task automatic start();
    #7 cs_n = 1'b0;
    drv_en_r = 1'b1;
  endtask
  task automatic stop();
    #7 cs_n = 1'b1;
  endtask
  // MSB first, one bit on lane 0 or a nibble per clock
  task automatic send(input logic [31:0] v, input int nb, input int ln, input logic rel);
    for (int i = nb - ln; i >= 0; i -= ln) begin
      drv_r = (ln == 4) ? v[i +: 4] : {3'h0, v[i]};
      #15 sclk = 1'b1;
      #5 drv_en_r = drv_en_r & !(i == 0 && rel);
      #10 sclk = 1'b0;
    end
  endtask
  task automatic dummy(input int n);
    if (n > 0) drv_en_r = 1'b0;
    idle(n);
  endtask
  // Nibbles change on falling edges, taken at the next rising edge
  task automatic get_byte(output logic [7:0] b);
    #15 sclk = 1'b1;
    b[7:4] = io_in;
    #15 sclk = 1'b0;
    #15 sclk = 1'b1;
    b[3:0] = io_in;
    #15 sclk = 1'b0;
  endtask
endmodule // qrw_host_model

// file: testbench/tb_top.sv
// Self-checking bench for the quad read, wrap and four-wire flash sequencer
`timescale 1ns/1ps
module tb_top;
  import qrw_pkg::*;
  // ****************
  // Design and partner
  // ****************
  logic clk, sys_rst, quad_enable_bit, erase_done, erase_req, four_wire_command_mode, cont_read_active;
  logic write_enable_latch, wrap_disable_bit, sclk, cs_n;
  logic [15:0] erase_page;
  logic [1:0] wrap_length_select, dummy_count_select;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] mem_addr, a;
  logic [7:0] mem_data;
  logic [31:0] seed = 32'hA0533DD5;
  logic [31:0] r;
  int num_errors = 0;
  int n_tests = 0;
  int n_erase = 0;
  int dm;
  qrw_flash_ctrl u_qrw_flash_ctrl (.clk(clk), .sys_rst(sys_rst), .quad_enable_bit(quad_enable_bit),
    .erase_done(erase_done), .erase_req(erase_req), .erase_page(erase_page),
    .four_wire_command_mode(four_wire_command_mode),
    .cont_read_active(cont_read_active), .write_enable_latch(write_enable_latch), .wrap_disable_bit(wrap_disable_bit),
    .wrap_length_select(wrap_length_select), .dummy_count_select(dummy_count_select), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .mem_addr(mem_addr), .mem_data(mem_data));
  qrw_host_model u_qrw_host_model (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  assign mem_data = mem_fn(mem_addr);
  always @(negedge clk) if (erase_req === 1'b1) n_erase++;
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] mem_fn(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction
  // Next byte address; a wrapped read stays inside its aligned section
  function automatic logic [23:0] nxt(input logic [23:0] x, input logic wen, input logic [1:0] len);
    logic [23:0] m;
    m = (24'h000008 << len) - 24'h000001;
    return wen ? ((x & ~m) | ((x + 24'h000001) & m)) : x + 24'h000001;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Status outputs are synchronised copies, so let the link idle first
  task automatic settle();
    u_qrw_host_model.idle(4);
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] op, input int ln, input logic [31:0] arg, input int nb);
    u_qrw_host_model.start();
    u_qrw_host_model.send({24'h000000, op}, 8, ln, 1'b0);
    u_qrw_host_model.send(arg, nb, ln, 1'b0);
    u_qrw_host_model.stop();
    settle();
  endtask
  task automatic qrd(input logic [7:0] op, input int ln, input logic skip, input logic [23:0] x, input logic [7:0] md,
                     input int mb, input int dmy, input int n, input logic wen, input logic [1:0] len);
    logic [7:0] b;
    u_qrw_host_model.start();
    if (!skip) u_qrw_host_model.send({24'h000000, op}, 8, ln, 1'b0);
    u_qrw_host_model.send({8'h00, x}, 24, 4, 1'b0);
    u_qrw_host_model.send({24'h000000, md}, mb, 4, dmy == 0);
    u_qrw_host_model.dummy(dmy);
    for (int k = 0; k < n; k++) begin
      u_qrw_host_model.get_byte(b);
      check("read byte", {24'h000000, b}, {24'h000000, mem_fn(x)});
      x = nxt(x, wen, len);
    end
    u_qrw_host_model.stop();
    settle();
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    sys_rst = 1'b1;
    quad_enable_bit = 1'b0;
    erase_done = 1'b0;
    repeat (10) @(negedge clk);
    u_qrw_host_model.idle(3);
    @(negedge clk);
    sys_rst = 1'b0;
    settle();
    check("reset status", {wrap_disable_bit, four_wire_command_mode, cont_read_active, write_enable_latch,
      wrap_length_select, dummy_count_select}, 32'h80);
    @(negedge clk);
    quad_enable_bit = 1'b1;
    r = rnd();
    qrd(OP_QUAD_IO_READ, 1, 1'b0, r[23:0], {r[31:30], 2'h2, r[27:24]}, 8, DMY_STD_QUAD, 3, 1'b0, 2'h0);
    check("cont armed", cont_read_active, 32'h1);
    qrd(OP_QUAD_IO_READ, 1, 1'b1, r[23:0] ^ 24'h00F0F0, {r[31:30], 2'h1, r[27:24]}, 8, DMY_STD_QUAD, 2, 1'b0,
      2'h0);
    check("cont left", cont_read_active, 32'h0);
    qrd(OP_WORD_READ, 1, 1'b0, {r[23:1], 1'b0}, 8'h20, 8, DMY_WORD, 2, 1'b0, 2'h0);
    check("word cont armed", cont_read_active, 32'h1);
    frame(OP_EXIT_FW, 1, 32'h0, 0);
    check("cont reset", cont_read_active, 32'h0);
    for (int l = 0; l < 4; l++) begin
      r = rnd();
      frame(OP_WRAP_SETUP, 1, {r[31:8], r[7], l[1:0], 1'b0, r[3:0]}, 32);
      check("wrap set", {wrap_disable_bit, wrap_length_select}, {1'b0, l[1:0]});
      a = (r[23:0] | ((24'h000008 << l) - 24'h000001)) - 24'h000001;
      qrd(l[0] ? OP_WORD_READ : OP_QUAD_IO_READ, 1, 1'b0, a, 8'h00, 8, l[0] ? DMY_WORD : DMY_STD_QUAD, 4, 1'b1,
        l[1:0]);
    end
    frame(OP_WRAP_SETUP, 1, 32'h00000070, 32);
    check("wrap off", {wrap_disable_bit, wrap_length_select}, 32'h7);
    qrd(OP_QUAD_IO_READ, 1, 1'b0, a, 8'h00, 8, DMY_STD_QUAD, 3, 1'b0, 2'h0);
    qrd(OP_OCTAL_READ, 1, 1'b0, {r[23:4], 4'h0}, {4'h3, r[3:0]}, 8, DMY_OCTAL, 2, 1'b0, 2'h0);
    frame(OP_PAGE_ERASE, 1, r, 24);
    check("erase refused", n_erase, 32'h0);
    frame(OP_WRITE_ENABLE, 1, 32'h0, 0);
    check("latch set", write_enable_latch, 32'h1);
    @(negedge clk);
    quad_enable_bit = 1'b0;
    frame(OP_ENTER_FW, 1, 32'h0, 0);
    check("entry refused", four_wire_command_mode, 32'h0);
    @(negedge clk);
    quad_enable_bit = 1'b1;
    frame(OP_ENTER_FW, 1, 32'h0, 0);
    check("entry kept", {four_wire_command_mode, write_enable_latch, wrap_length_select},
      32'hF);
    r = rnd();
    frame(OP_PAGE_ERASE, 4, r, 24);
    check("erase page", {n_erase[15:0], erase_page}, {16'h0001, r[23:8]});
    @(negedge clk);
    erase_done = 1'b1;
    @(negedge clk);
    erase_done = 1'b0;
    settle();
    check("latch cleared", write_enable_latch, 32'h0);
    for (int d = 0; d < 4; d++) begin
      r = rnd();
      frame(OP_READ_PARAM, 4, {26'h0, d[1:0], 2'h0, r[1:0]}, 8);
      check("read params", {dummy_count_select, wrap_length_select}, {d[1:0], r[1:0]});
      dm = (d == 3) ? DMY_P_HIGH : (d == 2) ? DMY_P_MID : DMY_P_LOW;
      a = r[23:0] | ((24'h000008 << r[1:0]) - 24'h000001);
      qrd(OP_QUAD_IO_READ, 4, 1'b0, a, 8'h00, 8, dm - 2, 3, 1'b0, 2'h0);
      qrd(OP_WRAP_READ, 4, 1'b0, a, 8'h00, 0, dm, 3, 1'b1, r[1:0]);
    end
    qrd(OP_QUAD_IO_READ, 4, 1'b0, a, 8'h20, 8, dm - 2, 1, 1'b0, 2'h0);
    check("four-wire cont", cont_read_active, 32'h1);
    qrd(OP_QUAD_IO_READ, 4, 1'b1, a, 8'h00, 8, dm - 2, 1, 1'b0, 2'h0);
    frame(OP_EXIT_FW, 4, 32'h0, 0);
    check("exit", {cont_read_active, four_wire_command_mode, wrap_length_select},
      {2'h0, r[1:0]});
    close_out();
  end
  // Plan needs well under 100 us; a hang stops at 300 us
  initial begin
    #300000;
    num_errors++;
    close_out();
  end
endmodule // tb_top
